//--- logic/cst_pkg.sv
/*
  Package for the CAN status, timing and filter register block.
  Assumes a 32-bit APB slave view with one aligned word per register.
*/
package cst_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam logic [11:0] OFF_INTERRUPT_FLAGS = 12'h000;
  localparam logic [11:0] OFF_INTERRUPT_ENABLES = 12'h004;
  localparam logic [11:0] OFF_ERROR_COUNTERS = 12'h008;
  localparam logic [11:0] OFF_BIT_TIMING_ONE = 12'h00C;
  localparam logic [11:0] OFF_BIT_TIMING_TWO = 12'h010;
  localparam logic [11:0] OFF_FILTER_ENABLES = 12'h014;
  localparam logic [11:0] OFF_FILTER_TARGET_LO = 12'h018;
  localparam logic [11:0] OFF_MODE_CONTROL = 12'h01C;

  localparam int unsigned FLAG_TX_BUFFER = 0;
  localparam int unsigned FLAG_RX_BUFFER = 1;
  localparam int unsigned FLAG_RX_OVERFLOW = 2;
  localparam int unsigned FLAG_FIFO_FULL = 3;
  localparam int unsigned FLAG_ERROR = 5;
  localparam int unsigned FLAG_WAKEUP = 6;
  localparam int unsigned FLAG_INVALID = 7;
  localparam logic [7:0] FLAG_MASK = 8'hEF;

  localparam logic [7:0] BT1_MASK = 8'hFF;
  localparam logic [15:0] BT2_MASK = 16'h47FF;
  localparam logic [15:0] FILTER_EN_RESET = 16'hFFFF;
  localparam logic [15:0] BT2_RESET = 16'h0000;

  localparam logic [2:0] MODE_CONFIG = 3'h4;
  localparam logic [2:0] MODE_RESET = 3'h4;

  localparam logic [3:0] TARGET_FIFO = 4'hF;

  localparam logic [8:0] WARN_LIMIT = 9'h060;
  localparam logic [8:0] PASSIVE_LIMIT = 9'h080;
  localparam logic [8:0] BUSOFF_LIMIT = 9'h100;
  localparam logic [5:0] IPT_QUANTA = 6'h02;
endpackage

//--- logic/cst_regs.sv
/*
  CAN status, error counters, bit timing and filter steering registers.
  Assumes an APB master on i_sys_clk and event pulses from core logic
  on the same clock; the bus line input is asynchronous.
*/
// Added by the designer: the register addresses and the APB slave port.
`timescale 1ns/1ps
// What this block does
// - Read-only transmit/receive error state indications
// - Error flag sets on error state activation
// - Invalid message flag, reset zero, clear-only
// - Wake-up activity sets clear-only flag
// - FIFO almost full sets clear-only flag
// - Receive buffer overflow sets clear-only flag
// - Receive and transmit buffer clear-only flags
// - Enable per flag gates interrupt request
// - Transmit error counter in upper byte
// - Receive error counter in lower byte
// - Jump width equals field plus one
// - Quantum is prescaler plus one
// - Phase two length equals field plus one
// - Phase two select picks programmed or derived
// - Triple or single sampling per select bit
// - Phase one length equals field plus one
// - Propagation length equals field plus one
// - Wake-up path optionally through line filter
// - Sixteen filter enables, reset one, gate acceptance
// - Filter hit steers to buffer or FIFO
// - Filters zero to three pointers, low nibble first
// - Mode request field, code four is configuration
module cst_regs #(
  parameter int unsigned FILTER_N = 16
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [cst_pkg::ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic [8:0] i_tx_error_count,
  input wire logic [7:0] i_rx_error_count,
  input wire logic i_invalid_msg,
  input wire logic i_wakeup_activity,
  input wire logic i_fifo_almost_full,
  input wire logic i_rx_overflow,
  input wire logic i_rx_buffer_event,
  input wire logic i_tx_buffer_event,
  input wire logic i_can_rx,
  input wire logic [FILTER_N-1:0] i_filter_match,
  output logic o_irq,
  output logic [6:0] o_resync_jump_quanta,
  output logic [6:0] o_quantum_clocks,
  output logic [3:0] o_phase_one_quanta,
  output logic [3:0] o_phase_two_quanta,
  output logic [3:0] o_propagation_quanta,
  output logic o_triple_sample,
  output logic o_wakeup_line,
  output logic o_config_mode,
  output logic [2:0] o_requested_operation_mode,
  output logic o_hit_valid,
  output logic [3:0] o_hit_filter,
  output logic o_hit_to_fifo,
  output logic [3:0] o_hit_buffer
);
  import cst_pkg::*;

  logic [7:0] flags;
  logic [7:0] enables;
  logic [7:0] bit_timing_one;
  logic [15:0] bit_timing_two;
  logic [15:0] filter_enables;
  logic [15:0] filter_target_lo;
  logic [2:0] requested_operation_mode;
  logic [5:0] err_state_q;
  logic rx_meta;
  logic rx_sync;
  logic [2:0] rx_hist;
  logic line_filtered;

  function automatic logic [3:0] plus_one3(input logic [2:0] v);
    return {1'b0, v} + 4'h1;
  endfunction

  wire [3:0] jump_q = plus_one3({1'b0, bit_timing_one[7:6]});

  // Error state indications from the counters
  wire tx_busoff_state = i_tx_error_count >= BUSOFF_LIMIT;
  wire tx_passive_state = !tx_busoff_state && (i_tx_error_count >= PASSIVE_LIMIT);
  wire rx_passive_state = {1'b0, i_rx_error_count} >= PASSIVE_LIMIT;
  wire tx_warning_state = i_tx_error_count >= WARN_LIMIT;
  wire rx_warning_state = {1'b0, i_rx_error_count} >= WARN_LIMIT;
  wire any_warning_state = tx_warning_state || rx_warning_state;
  wire [5:0] err_state = {tx_busoff_state, tx_passive_state, rx_passive_state,
                          tx_warning_state, rx_warning_state, any_warning_state};
  wire err_rise = |(err_state & ~err_state_q);

  // APB decode
  wire access = i_psel && i_penable;
  wire wr = access && i_pwrite;
  wire hit_flags = i_paddr == OFF_INTERRUPT_FLAGS;
  wire hit_en = i_paddr == OFF_INTERRUPT_ENABLES;
  wire hit_ec = i_paddr == OFF_ERROR_COUNTERS;
  wire hit_bt1 = i_paddr == OFF_BIT_TIMING_ONE;
  wire hit_bt2 = i_paddr == OFF_BIT_TIMING_TWO;
  wire hit_fen = i_paddr == OFF_FILTER_ENABLES;
  wire hit_ftg = i_paddr == OFF_FILTER_TARGET_LO;
  wire hit_mode = i_paddr == OFF_MODE_CONTROL;
  wire mapped = hit_flags || hit_en || hit_ec || hit_bt1 || hit_bt2 ||
                hit_fen || hit_ftg || hit_mode;
  wire [15:0] wmask16 = {{8{i_pstrb[1]}}, {8{i_pstrb[0]}}};
  wire [15:0] wdata16 = i_pwdata[15:0];

  // Writing zero clears a flag; writing one keeps it
  wire [7:0] flag_clear = (wr && hit_flags && i_pstrb[0]) ? ~wdata16[7:0] : 8'h00;
  wire [7:0] flag_set = {i_invalid_msg, i_wakeup_activity, err_rise, 1'b0,
                         i_fifo_almost_full, i_rx_overflow, i_rx_buffer_event,
                         i_tx_buffer_event};
  wire [7:0] next_flags = ((flags & ~flag_clear) | flag_set) & FLAG_MASK;

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] mask);
    return (old & ~wmask16) | (wdata16 & wmask16 & mask);
  endfunction

  wire [15:0] next_enables16 = merge16({8'h00, enables}, {8'h00, FLAG_MASK});
  wire [15:0] next_bt1_16 = merge16({8'h00, bit_timing_one}, {8'h00, BT1_MASK});
  wire [15:0] flags_word = {2'b00, err_state, flags};
  wire [15:0] ec_word = {i_tx_error_count[7:0], i_rx_error_count};
  wire [15:0] rdata16 =
    hit_flags ? flags_word :
    hit_en ? {8'h00, enables} :
    hit_ec ? ec_word :
    hit_bt1 ? {8'h00, bit_timing_one} :
    hit_bt2 ? bit_timing_two :
    hit_fen ? filter_enables :
    hit_ftg ? filter_target_lo :
    hit_mode ? {13'h0000, requested_operation_mode} : 16'h0000;

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      flags <= 8'h00;
      err_state_q <= 6'h00;
    end else begin
      flags <= next_flags;
      err_state_q <= err_state;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      enables <= 8'h00;
      bit_timing_one <= 8'h00;
      bit_timing_two <= BT2_RESET;
      filter_enables <= FILTER_EN_RESET;
      filter_target_lo <= 16'h0000;
      requested_operation_mode <= MODE_RESET;
    end else if (wr) begin
      if (hit_en) enables <= next_enables16[7:0];
      if (hit_bt1) bit_timing_one <= next_bt1_16[7:0];
      if (hit_bt2) bit_timing_two <= merge16(bit_timing_two, BT2_MASK);
      if (hit_fen) filter_enables <= merge16(filter_enables, 16'hFFFF);
      if (hit_ftg) filter_target_lo <= merge16(filter_target_lo, 16'hFFFF);
      if (hit_mode && i_pstrb[0]) requested_operation_mode <= wdata16[2:0];
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_prdata <= 32'h0000_0000;
    end else if (i_psel && !i_penable && !i_pwrite) begin
      o_prdata <= {16'h0000, rdata16};
    end
  end

  assign o_pready = 1'b1;
  assign o_pslverr = access && !mapped;
  assign o_irq = |(flags & enables);

  // Bit timing decode
  wire [2:0] phase_two_length = bit_timing_two[10:8];
  wire phase_two_select = bit_timing_two[7];
  wire triple_sample_select = bit_timing_two[6];
  wire [2:0] phase_one_length = bit_timing_two[5:3];
  wire [2:0] propagation_length = bit_timing_two[2:0];
  wire wakeup_line_filter_select = bit_timing_two[14];
  wire [3:0] phase_one_q = plus_one3(phase_one_length);
  wire [3:0] derived_phase_two = ({2'b00, phase_one_q} >= IPT_QUANTA) ? phase_one_q
                                 : IPT_QUANTA[3:0];
  assign o_resync_jump_quanta = {3'h0, jump_q};
  assign o_quantum_clocks = {1'b0, bit_timing_one[5:0]} + 7'h01;
  assign o_phase_one_quanta = phase_one_q;
  assign o_phase_two_quanta = phase_two_select ? plus_one3(phase_two_length)
                              : derived_phase_two;
  assign o_propagation_quanta = plus_one3(propagation_length);
  assign o_triple_sample = triple_sample_select;
  assign o_requested_operation_mode = requested_operation_mode;
  assign o_config_mode = requested_operation_mode == MODE_CONFIG;

  // Bus line synchroniser and three-sample agreement filter for wake-up
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
      rx_hist <= 3'h7;
      line_filtered <= 1'b1;
    end else begin
      rx_meta <= i_can_rx;
      rx_sync <= rx_meta;
      rx_hist <= {rx_hist[1:0], rx_sync};
      line_filtered <= (rx_hist == 3'h7) ? 1'b1 : (rx_hist == 3'h0) ? 1'b0 : line_filtered;
    end
  end
  assign o_wakeup_line = wakeup_line_filter_select ? line_filtered : rx_sync;

  // Lowest enabled matching filter wins
  wire [FILTER_N-1:0] accepted = i_filter_match & filter_enables[FILTER_N-1:0];
  logic [3:0] win;
  always_comb begin
    win = 4'h0;
    for (int i = FILTER_N - 1; i >= 0; i--) begin
      if (accepted[i]) win = 4'(i);
    end
  end
  wire [3:0] target = (win < 4'h4) ? filter_target_lo[{win[1:0], 2'b00} +: 4] : TARGET_FIFO;

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_hit_valid <= 1'b0;
      o_hit_filter <= 4'h0;
      o_hit_to_fifo <= 1'b0;
      o_hit_buffer <= 4'h0;
    end else begin
      o_hit_valid <= |accepted;
      o_hit_filter <= win;
      o_hit_to_fifo <= target == TARGET_FIFO;
      o_hit_buffer <= target;
    end
  end
endmodule

//--- tb/cst_bus_model.sv
/* Bus line seen through the transceiver.
   Assumes the bench asks for dominant; recessive high otherwise. */
`timescale 1ns/1ps
module cst_bus_model (
  input wire logic i_sys_clk,
  input wire logic i_drive_dominant,
  output logic o_can_rx
);
  initial o_can_rx = 1'b1;
  // Recessive unless some node drives dominant
  always @(posedge i_sys_clk) o_can_rx <= !i_drive_dominant;
endmodule

//--- tb/cst_regs_properties.sv
/* Port checker for cst_regs.
   Assumes one clock and an active-low reset. */
`timescale 1ns/1ps
module cst_regs_chk #(
  parameter int unsigned FILTER_N = 16
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic [FILTER_N-1:0] i_filter_match,
  input wire logic [6:0] o_resync_jump_quanta,
  input wire logic [6:0] o_quantum_clocks,
  input wire logic [3:0] o_phase_one_quanta,
  input wire logic [3:0] o_phase_two_quanta,
  input wire logic [3:0] o_propagation_quanta,
  input wire logic o_hit_valid,
  input wire logic [3:0] o_hit_filter,
  input wire logic o_hit_to_fifo,
  input wire logic [3:0] o_hit_buffer,
  input wire logic o_pslverr
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  a_jump_range: assert property (o_resync_jump_quanta inside {[1:4]})
    else $error("jump width out of range");
  a_quantum_range: assert property (o_quantum_clocks inside {[1:64]})
    else $error("prescaler out of range");
  a_phase_two_range: assert property (o_phase_two_quanta inside {[1:8]})
    else $error("phase two out of range");
  a_phase_one_range: assert property (o_phase_one_quanta inside {[1:8]})
    else $error("phase one out of range");
  a_prop_range: assert property (o_propagation_quanta inside {[1:8]})
    else $error("propagation out of range");
  a_hit_needs_match: assert property (!(|i_filter_match) |=> !o_hit_valid)
    else $error("hit without match");
  a_buffer_code: assert property (o_hit_valid && !o_hit_to_fifo |-> o_hit_buffer != 4'hF)
    else $error("fifo code used as buffer");
  a_high_filter_fifo: assert property (o_hit_valid && o_hit_filter > 3 |-> o_hit_to_fifo)
    else $error("upper filter not to fifo");
  c_hit_fifo: cover property (o_hit_valid && o_hit_to_fifo);
  c_hit_buffer: cover property (o_hit_valid && !o_hit_to_fifo);
  c_bad_addr: cover property (o_pslverr);
endmodule
bind cst_regs cst_regs_chk #(.FILTER_N(FILTER_N)) u_cst_regs_chk (.*);

//--- tb/testbench.sv
/* Self-checking bench for cst_regs.
   Assumes an APB master and a bus line model on the far side. */
`timescale 1ns/1ps
module testbench;
  import cst_pkg::*;
  logic i_sys_clk = 0, i_rst_n = 0, i_psel = 0, i_penable = 0, i_pwrite = 0, dom = 0;
  logic [11:0] i_paddr = 12'h000;
  logic [31:0] i_pwdata = 32'h0, o_prdata, rd, d;
  logic [3:0] i_pstrb = 4'hF;
  logic [8:0] i_tx_error_count = 9'h000;
  logic [7:0] i_rx_error_count = 8'h00;
  logic [5:0] ev = 6'h00;
  logic [15:0] i_filter_match = 16'h0000;
  logic i_can_rx, o_pready, o_pslverr, o_irq, o_triple_sample, o_wakeup_line;
  logic o_config_mode, o_hit_valid, o_hit_to_fifo;
  logic [6:0] o_resync_jump_quanta, o_quantum_clocks;
  logic [3:0] o_phase_one_quanta, o_phase_two_quanta, o_propagation_quanta;
  logic [3:0] o_hit_filter, o_hit_buffer;
  logic [2:0] o_requested_operation_mode;
  wire i_invalid_msg = ev[0], i_wakeup_activity = ev[1], i_fifo_almost_full = ev[2];
  wire i_rx_overflow = ev[3], i_rx_buffer_event = ev[4], i_tx_buffer_event = ev[5];
  int errors = 0, num_checks = 0, cyc = 0, i;
  int fbit [6] = '{7, 6, 3, 2, 1, 0};
  integer seed = 32'hf7f6d684;
  cst_regs u_cst_regs (.*);
  cst_bus_model u_cst_bus_model (.i_sys_clk, .i_drive_dominant(dom), .o_can_rx(i_can_rx));
  always #2.5 i_sys_clk = ~i_sys_clk;
  task automatic print_verdict();
    if (errors == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge i_sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      print_verdict();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge i_sys_clk);
    i_psel <= 1;
    i_penable <= 0;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= wd;
    @(posedge i_sys_clk);
    i_penable <= 1;
    do @(posedge i_sys_clk); while (o_pready !== 1'b1);
    rd = o_prdata;
    d[31] = o_pslverr;
    i_psel <= 0;
    i_penable <= 0;
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(0, a, 32'h0);
    chk(rd, exp);
  endtask
  function automatic logic [31:0] p2_exp(input logic [31:0] v);
    logic [31:0] a;
    a = v[5:3] + 1;
    if (v[7]) return v[10:8] + 1;
    return (a > IPT_QUANTA) ? a : IPT_QUANTA;
  endfunction
  initial begin
    repeat (20) @(posedge i_sys_clk);
    i_rst_n <= 1;
    rdchk(OFF_INTERRUPT_FLAGS, 0);
    rdchk(OFF_INTERRUPT_ENABLES, 0);
    rdchk(OFF_FILTER_ENABLES, 32'hFFFF);
    rdchk(OFF_FILTER_TARGET_LO, 0);
    rdchk(12'h020, 0);
    chk(d[31], 1);
    // Timing set up while still in configuration mode
    for (i = 0; i < 8; i++) begin
      d = (i == 0) ? 32'h0 : (i == 1) ? 32'h47FF : $random(seed);
      apb(1, OFF_BIT_TIMING_ONE, d);
      apb(1, OFF_BIT_TIMING_TWO, d);
      rdchk(OFF_BIT_TIMING_ONE, d & 32'hFF);
      rdchk(OFF_BIT_TIMING_TWO, d & 32'h47FF);
      chk(o_resync_jump_quanta, d[7:6] + 1);
      chk(o_quantum_clocks, d[5:0] + 1);
      chk(o_phase_one_quanta, d[5:3] + 1);
      chk(o_propagation_quanta, d[2:0] + 1);
      chk(o_triple_sample, d[6]);
      chk(o_phase_two_quanta, p2_exp(d));
    end
    rdchk(OFF_MODE_CONTROL, MODE_CONFIG);
    chk(o_config_mode, 1);
    apb(1, OFF_MODE_CONTROL, 0);
    rdchk(OFF_MODE_CONTROL, 0);
    chk({o_config_mode, o_requested_operation_mode}, 0);
    for (i = 0; i < 6; i++) begin
      ev <= 6'h01 << i;
      @(posedge i_sys_clk);
      ev <= 6'h00;
      rdchk(OFF_INTERRUPT_FLAGS, 32'h1 << fbit[i]);
      chk(o_irq, 0);
      apb(1, OFF_INTERRUPT_ENABLES, 32'h1 << fbit[i]);
      @(negedge i_sys_clk);
      chk(o_irq, 1);
      apb(1, OFF_INTERRUPT_FLAGS, 0);
      apb(1, OFF_INTERRUPT_FLAGS, 32'hFF);
      rdchk(OFF_INTERRUPT_FLAGS, 0);
      apb(1, OFF_INTERRUPT_ENABLES, 0);
    end
    i_tx_error_count <= 9'h060;
    i_rx_error_count <= 8'h5A;
    rdchk(OFF_ERROR_COUNTERS, 32'h605A);
    chk(rd, 32'h605A);
    rdchk(OFF_INTERRUPT_FLAGS, 32'h0520);
    i_tx_error_count <= 9'h100;
    i_rx_error_count <= 8'h80;
    rdchk(OFF_ERROR_COUNTERS, 32'h0080);
    apb(0, OFF_INTERRUPT_FLAGS, 0);
    chk(rd & 32'h3800, 32'h2800);
    d = $random(seed);
    d[7:0] = 8'hEF;
    apb(1, OFF_FILTER_TARGET_LO, d);
    rdchk(OFF_FILTER_TARGET_LO, d & 32'hFFFF);
    apb(1, OFF_FILTER_ENABLES, 32'hFFF7);
    for (i = 0; i < 6; i++) begin
      i_filter_match <= 16'h1 << i;
      repeat (2) @(posedge i_sys_clk);
      @(negedge i_sys_clk);
      chk(o_hit_valid, i != 3);
      if (i != 3) chk({o_hit_filter, o_hit_to_fifo}, {i[3:0], i > 3 || d[4*i+:4] == 4'hF});
      if (i < 3 && d[4*i+:4] != 4'hF) chk(o_hit_buffer, d[4*i+:4]);
    end
    for (i = 0; i < 2; i++) begin
      apb(1, OFF_BIT_TIMING_TWO, i << 14);
      dom <= 1;
      repeat (10) @(posedge i_sys_clk);
      chk(o_wakeup_line, 0);
      dom <= 0;
      repeat (10) @(posedge i_sys_clk);
      chk(o_wakeup_line, 1);
    end
    print_verdict();
  end
endmodule
